/* File: include/xfer_test_wait_pkg.sv */
package xfer_test_wait_pkg;
   // opcodes
   localparam logic [7:0] OP_PREBYTE      = 8'h18;
   localparam logic [7:0] OP_SP_TO_IDX    = 8'h30;
   localparam logic [7:0] OP_IDX_TO_SP    = 8'h35;
   localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h06;
   localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h07;
   localparam logic [7:0] OP_MEM_CHK_EXT  = 8'h7D;
   localparam logic [7:0] OP_MEM_CHK_IDX  = 8'h6D;
   localparam logic [7:0] OP_ACC_A_CHK    = 8'h4D;
   localparam logic [7:0] OP_ACC_B_CHK    = 8'h5D;
   localparam logic [7:0] OP_BUS_COUNT    = 8'h00;
   localparam logic [7:0] OP_WAIT_IRQ     = 8'h3E;
   // cycle counts (opcode fetch counts as cycle 1)
   localparam logic [3:0] CYC_XFER        = 4'h3;
   localparam logic [3:0] CYC_INH2        = 4'h2;
   localparam logic [3:0] CYC_MEM_CHK     = 4'h6;
   localparam logic [3:0] CYC_WAIT_STACK  = 4'hC;
   localparam logic [3:0] CYC_VECTOR      = 4'h2;
   // flag bit positions: S X H I N Z V C
   localparam int FLAG_X = 6;
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_V = 1;
   localparam int FLAG_C = 0;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [15:0] SP_RESET  = 16'h0000;
   localparam logic [15:0] ONE_WORD  = 16'h0001;
   localparam logic [7:0]  FLAGS_RESET = 8'hD0;
   typedef enum logic [1:0] {ADDR_DIRECT, ADDR_INDEXED, ADDR_RELATIVE, ADDR_EXTENDED} addr_mode_t;
endpackage

/* File: rtl/cpu_transfer_test_wait_decode.sv */
`timescale 1ns/100ps
// Overview of operation
// - opcode 30: stack pointer plus one to index x, 3 cycles, flags kept
// - prebyte 18 30: stack pointer plus one to index y, 4 cycles, flags kept
// - opcode 35: index x minus one to stack pointer, 3 cycles, flags kept
// - prebyte 18 35: index y minus one to stack pointer, 4 cycles
// - opcode 06: a to flags, 2 cycles, x mask may clear never set
// - opcode 07: flags to a, 2 cycles, flags kept
// - memory test: n,z from operand, v,c cleared; 6 or 7 cycles
// - accumulator tests 4D/5D: 2 cycles, n,z from value, v,c cleared
// - opcode 00 only in test mode: address bus counts until reset
// - wait opcode 3E: 12 cycles stacking, then idles until interrupt
// - two vector fetch cycles follow; total fourteen plus idle count
// - direct operand is low address byte, high byte forced zero
// - indexed operand is unsigned offset added to index register
// - relative operand is signed, added to address after offset byte
// - sixteen-bit immediate arrives high byte first, then low byte
// - extended address arrives high byte first, then low byte
module cpu_transfer_test_wait_decode (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_op_valid,
   input  wire logic [7:0]  i_op_byte,
   input  wire logic [7:0]  i_operand_hi,
   input  wire logic [7:0]  i_operand_lo,
   input  wire logic [7:0]  i_mem_data,
   input  wire logic [1:0]  i_addr_mode,
   input  wire logic [15:0] i_next_pc,
   input  wire logic        i_test_mode,
   input  wire logic        i_irq_pending,
   output logic             o_busy,
   output logic             o_done,
   output logic             o_illegal,
   output logic             o_waiting,
   output logic             o_vector_fetch,
   output logic [15:0]      o_addr,
   output logic [15:0]      o_imm16,
   output logic [15:0]      o_stack_pointer,
   output logic [15:0]      o_index_reg_x,
   output logic [15:0]      o_index_reg_y,
   output logic [7:0]       o_acc_a,
   output logic [7:0]       o_acc_b,
   output logic [7:0]       o_flags_register
);

   typedef enum logic [2:0] {ST_FETCH, ST_EXEC, ST_STACK, ST_IDLE, ST_VECTOR,
                             ST_BUS_COUNT} state_t;

   // test mode and interrupt pins pass two flip-flops first
   logic        test_meta_q, test_sync_q, irq_meta_q, irq_sync_q;
   always_ff @(posedge i_core_clk) begin
      test_meta_q <= i_test_mode;
      test_sync_q <= test_meta_q;
      irq_meta_q  <= i_irq_pending;
      irq_sync_q  <= irq_meta_q;
   end

   state_t      state_q, state_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        pre_q, pre_d;
   logic [7:0]  op_q, op_d;
   logic        busy_q, busy_d, done_q, done_d, ill_q, ill_d;
   logic        wait_q, wait_d, vec_q, vec_d;
   logic [15:0] addr_q, addr_d, imm_q, imm_d;
   logic [15:0] sp_q, sp_d, ix_q, ix_d, iy_q, iy_d;
   logic [7:0]  a_q, a_d, b_q, b_d, cc_q, cc_d;

   // n,z from value, v and c cleared
   function automatic logic [7:0] zero_check(input logic [7:0] cc, input logic [7:0] v);
      logic [7:0] r;
      r = cc;
      r[xfer_test_wait_pkg::FLAG_N] = v[7];
      r[xfer_test_wait_pkg::FLAG_Z] = (v == xfer_test_wait_pkg::ZERO_BYTE);
      r[xfer_test_wait_pkg::FLAG_V] = 1'b0;
      r[xfer_test_wait_pkg::FLAG_C] = 1'b0;
      return r;
   endfunction

   // remaining cycles after fetch for a given opcode
   function automatic logic [3:0] op_cycles(input logic [7:0] op, input logic pre);
      logic [3:0] c;
      c = xfer_test_wait_pkg::CYC_INH2;
      if (op == xfer_test_wait_pkg::OP_SP_TO_IDX || op == xfer_test_wait_pkg::OP_IDX_TO_SP)
         c = xfer_test_wait_pkg::CYC_XFER;
      else if (op == xfer_test_wait_pkg::OP_MEM_CHK_EXT || op == xfer_test_wait_pkg::OP_MEM_CHK_IDX)
         c = xfer_test_wait_pkg::CYC_MEM_CHK;
      // the prebyte edge itself is the extra fetch cycle, so it adds nothing here
      return c - 4'h1 + {3'b000, pre & 1'b0};
   endfunction

   // effective address by mode
   function automatic logic [15:0] eff_addr(input logic [1:0] m, input logic [7:0] hi,
                                             input logic [7:0] lo, input logic [15:0] idx,
                                             input logic [15:0] pc);
      logic [15:0] r;
      case (m)
         2'b00:   r = {xfer_test_wait_pkg::ZERO_BYTE, lo};
         2'b01:   r = idx + {xfer_test_wait_pkg::ZERO_BYTE, lo};
         2'b10:   r = pc + {{8{lo[7]}}, lo};
         default: r = {hi, lo};
      endcase
      return r;
   endfunction

   // sequencing and execution next state
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      pre_d   = pre_q;
      op_d    = op_q;
      busy_d  = busy_q;
      done_d  = 1'b0;
      ill_d   = 1'b0;
      wait_d  = 1'b0;
      vec_d   = 1'b0;
      addr_d  = addr_q;
      imm_d   = imm_q;
      sp_d    = sp_q;
      ix_d    = ix_q;
      iy_d    = iy_q;
      a_d     = a_q;
      b_d     = b_q;
      cc_d    = cc_q;
      case (state_q)
         ST_FETCH: begin
            busy_d = 1'b0;
            if (i_op_valid) begin
               if (i_op_byte == xfer_test_wait_pkg::OP_PREBYTE && !pre_q) begin
                  pre_d  = 1'b1;
                  busy_d = 1'b1;
               end else begin
                  op_d    = i_op_byte;
                  busy_d  = 1'b1;
                  imm_d   = {i_operand_hi, i_operand_lo};
                  addr_d  = eff_addr(i_addr_mode, i_operand_hi, i_operand_lo,
                                     pre_q ? iy_q : ix_q, i_next_pc);
                  cnt_d   = op_cycles(i_op_byte, pre_q);
                  state_d = ST_EXEC;
                  if (i_op_byte == xfer_test_wait_pkg::OP_WAIT_IRQ) begin
                     cnt_d   = xfer_test_wait_pkg::CYC_WAIT_STACK - 4'h2;
                     state_d = ST_STACK;
                  end else if (i_op_byte == xfer_test_wait_pkg::OP_BUS_COUNT) begin
                     if (test_sync_q) begin
                        addr_d  = xfer_test_wait_pkg::SP_RESET;
                        state_d = ST_BUS_COUNT;
                     end else begin
                        ill_d   = 1'b1;
                        pre_d   = 1'b0;
                        busy_d  = 1'b0;
                        state_d = ST_FETCH;
                     end
                  end
               end
            end
         end
         ST_EXEC: begin
            if (cnt_q > 4'h1) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               case (op_q)
                  xfer_test_wait_pkg::OP_SP_TO_IDX: begin
                     if (pre_q) iy_d = sp_q + xfer_test_wait_pkg::ONE_WORD;
                     else ix_d = sp_q + xfer_test_wait_pkg::ONE_WORD;
                  end
                  xfer_test_wait_pkg::OP_IDX_TO_SP: begin
                     if (pre_q) sp_d = iy_q - xfer_test_wait_pkg::ONE_WORD;
                     else sp_d = ix_q - xfer_test_wait_pkg::ONE_WORD;
                  end
                  xfer_test_wait_pkg::OP_ACC_TO_FLAGS: begin
                     cc_d = a_q;
                     cc_d[xfer_test_wait_pkg::FLAG_X] = a_q[xfer_test_wait_pkg::FLAG_X]
                                                        & cc_q[xfer_test_wait_pkg::FLAG_X];
                  end
                  xfer_test_wait_pkg::OP_FLAGS_TO_ACC: a_d = cc_q;
                  xfer_test_wait_pkg::OP_MEM_CHK_EXT,
                  xfer_test_wait_pkg::OP_MEM_CHK_IDX: cc_d = zero_check(cc_q, i_mem_data);
                  xfer_test_wait_pkg::OP_ACC_A_CHK: cc_d = zero_check(cc_q, a_q);
                  xfer_test_wait_pkg::OP_ACC_B_CHK: cc_d = zero_check(cc_q, b_q);
                  default: ill_d = 1'b1;
               endcase
               done_d  = 1'b1;
               busy_d  = 1'b0;
               pre_d   = 1'b0;
               state_d = ST_FETCH;
            end
         end
         ST_STACK: begin
            if (cnt_q > 4'h0) cnt_d = cnt_q - 4'h1;
            else begin
               state_d = ST_IDLE;
               wait_d  = 1'b1; // waiting stands for every idle cycle
            end
         end
         ST_IDLE: begin
            wait_d = 1'b1;
            if (irq_sync_q) begin
               wait_d  = 1'b0;
               vec_d   = 1'b1; // high for both vector cycles
               cnt_d   = xfer_test_wait_pkg::CYC_VECTOR - 4'h1;
               state_d = ST_VECTOR;
            end
         end
         ST_VECTOR: begin
            vec_d = 1'b1;
            if (cnt_q > 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               vec_d   = 1'b0;
               done_d  = 1'b1;
               busy_d  = 1'b0;
               pre_d   = 1'b0;
               state_d = ST_FETCH;
            end
         end
         ST_BUS_COUNT: addr_d = addr_q + xfer_test_wait_pkg::ONE_WORD;
         default: state_d = ST_FETCH;
      endcase
   end

   // state registers
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_q <= ST_FETCH;
         cnt_q   <= 4'h0;
         pre_q   <= 1'b0;
         op_q    <= 8'h00;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
         ill_q   <= 1'b0;
         wait_q  <= 1'b0;
         vec_q   <= 1'b0;
         addr_q  <= xfer_test_wait_pkg::SP_RESET;
         imm_q   <= xfer_test_wait_pkg::SP_RESET;
         sp_q    <= xfer_test_wait_pkg::SP_RESET;
         ix_q    <= xfer_test_wait_pkg::SP_RESET;
         iy_q    <= xfer_test_wait_pkg::SP_RESET;
         a_q     <= 8'h00;
         b_q     <= 8'h00;
         cc_q    <= xfer_test_wait_pkg::FLAGS_RESET;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         pre_q   <= pre_d;
         op_q    <= op_d;
         busy_q  <= busy_d;
         done_q  <= done_d;
         ill_q   <= ill_d;
         wait_q  <= wait_d;
         vec_q   <= vec_d;
         addr_q  <= addr_d;
         imm_q   <= imm_d;
         sp_q    <= sp_d;
         ix_q    <= ix_d;
         iy_q    <= iy_d;
         a_q     <= a_d;
         b_q     <= b_d;
         cc_q    <= cc_d;
      end
   end

   // outputs straight from flops
   assign o_busy           = busy_q;
   assign o_done           = done_q;
   assign o_illegal        = ill_q;
   assign o_waiting        = wait_q;
   assign o_vector_fetch   = vec_q;
   assign o_addr           = addr_q;
   assign o_imm16          = imm_q;
   assign o_stack_pointer  = sp_q;
   assign o_index_reg_x    = ix_q;
   assign o_index_reg_y    = iy_q;
   assign o_acc_a          = a_q;
   assign o_acc_b          = b_q;
   assign o_flags_register = cc_q;

endmodule

/* File: test/cpu_transfer_test_wait_decode_asserts.sv */
`timescale 1ns/100ps
module cpu_transfer_test_wait_decode_asserts (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_op_valid,
   input  wire logic [7:0]  i_op_byte,
   input  wire logic        o_busy,
   input  wire logic        o_done,
   input  wire logic        o_illegal,
   input  wire logic        o_waiting,
   input  wire logic        o_vector_fetch,
   input  wire logic [15:0] o_stack_pointer,
   input  wire logic [15:0] o_index_reg_x,
   input  wire logic [15:0] o_index_reg_y,
   input  wire logic [7:0]  o_acc_a,
   input  wire logic [7:0]  o_flags_register
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // opcode taken in fetch state
   logic fresh;
   assign fresh = i_op_valid && !o_busy;
   // done is registered, so it is sampled one edge after the last cycle
   sp_to_x_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_SP_TO_IDX |-> ##3
      o_done && o_index_reg_x == $past(o_stack_pointer, 3) + 16'h0001
      && o_flags_register == $past(o_flags_register, 3)) else $error("sp to x wrong");
   sp_to_y_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_PREBYTE ##1
      i_op_valid && i_op_byte == xfer_test_wait_pkg::OP_SP_TO_IDX |-> ##3 o_done
      && o_index_reg_y == $past(o_stack_pointer, 3) + 16'h0001) else $error("sp to y wrong");
   x_to_sp_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_IDX_TO_SP |-> ##3
      o_done && o_stack_pointer == $past(o_index_reg_x, 3) - 16'h0001) else $error("x to sp wrong");
   acc_a_chk_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_ACC_A_CHK |-> ##2 o_done
      && o_flags_register[3:0] == {$past(o_acc_a[7], 2), $past(o_acc_a, 2) == 8'h00, 2'h0})
      else $error("acc a test flags wrong");
   flags_to_a_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_FLAGS_TO_ACC |-> ##2
      o_done && o_acc_a == $past(o_flags_register, 2) && $stable(o_flags_register))
      else $error("flags to a wrong");
   x_mask_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_ACC_TO_FLAGS |-> ##2 o_done
      && o_flags_register == {$past(o_acc_a[7], 2),
      $past(o_acc_a[6], 2) & $past(o_flags_register[6], 2), $past(o_acc_a[5:0], 2)})
      else $error("a to flags wrong");
   mem_chk_a: assert property (
      fresh && i_op_byte == xfer_test_wait_pkg::OP_MEM_CHK_EXT |-> ##6
      o_done && o_flags_register[1:0] == 2'h0) else $error("memory test wrong");
   vector_len_a: assert property (
      $rose(o_vector_fetch) |=> o_vector_fetch ##1 !o_vector_fetch)
      else $error("vector fetch length wrong");
   // main scenarios
   cover property ($rose(o_waiting));
   cover property (o_illegal);
   cover property ($rose(o_vector_fetch));
endmodule
bind cpu_transfer_test_wait_decode cpu_transfer_test_wait_decode_asserts u_asserts (
   .i_core_clk(i_core_clk), .i_reset(i_reset), .i_op_valid(i_op_valid), .i_op_byte(i_op_byte),
   .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_waiting(o_waiting),
   .o_vector_fetch(o_vector_fetch), .o_stack_pointer(o_stack_pointer),
   .o_index_reg_x(o_index_reg_x), .o_index_reg_y(o_index_reg_y), .o_acc_a(o_acc_a),
   .o_flags_register(o_flags_register));

/* File: test/cpu_transfer_test_wait_decode_tb.sv */
`timescale 1ns/100ps
module cpu_transfer_test_wait_decode_tb;
   logic        clk, reset, op_valid, test_mode, irq, busy, done, illegal, waiting, vfetch;
   logic [7:0]  op_byte, hi, lo, mem, acc_a, acc_b, flags, m_a, m_f;
   logic [1:0]  mode;
   logic [15:0] next_pc, addr, imm16, sp, ix, iy, m_sp, m_x, m_y, a0;
   logic [31:0] r;
   int          miscompares, check_count, wcnt, k;
   always #12.5 clk = ~clk;
   cpu_transfer_test_wait_decode dut (.i_core_clk(clk), .i_reset(reset), .i_op_valid(op_valid),
      .i_op_byte(op_byte), .i_operand_hi(hi), .i_operand_lo(lo), .i_mem_data(mem),
      .i_addr_mode(mode), .i_next_pc(next_pc), .i_test_mode(test_mode), .i_irq_pending(irq),
      .o_busy(busy), .o_done(done), .o_illegal(illegal), .o_waiting(waiting),
      .o_vector_fetch(vfetch), .o_addr(addr), .o_imm16(imm16), .o_stack_pointer(sp),
      .o_index_reg_x(ix), .o_index_reg_y(iy), .o_acc_a(acc_a), .o_acc_b(acc_b),
      .o_flags_register(flags));
   // idle cycles of the wait, interrupt raised on the fourth
   always @(negedge clk) if (waiting === 1'b1) begin
      wcnt <= wcnt + 1;
      if (wcnt == 3) irq <= 1'b1;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // present opcode, count edges until completion
   task automatic go(input logic pb, input logic [7:0] op);
      @(negedge clk);
      op_valid = 1'b1;
      op_byte = pb ? xfer_test_wait_pkg::OP_PREBYTE : op;
      k = 0;
      if (pb) begin
         @(negedge clk);
         op_byte = op;
         k = 1;
      end
      @(negedge clk);
      op_valid = 1'b0;
      k++;
      while (done !== 1'b1 && illegal !== 1'b1 && k < 60) begin
         @(negedge clk);
         k++;
      end
      if (k >= 60) begin
         miscompares++;
         conclude;
      end
   endtask
   task automatic run(input logic pb, input logic [7:0] op, input int cyc);
      go(pb, op);
      check("cycles", 16'(k), 16'(cyc));
      check("sp", sp, m_sp);
      check("x", ix, m_x);
      check("y", iy, m_y);
      check("a", {8'h00, acc_a}, {8'h00, m_a});
      check("flags", {8'h00, flags}, {8'h00, m_f});
   endtask
   function automatic logic [15:0] ea(input logic pb);
      case (mode)
         xfer_test_wait_pkg::ADDR_DIRECT:   ea = {8'h00, lo};
         xfer_test_wait_pkg::ADDR_INDEXED:  ea = (pb ? m_y : m_x) + {8'h00, lo};
         xfer_test_wait_pkg::ADDR_RELATIVE: ea = next_pc + {{8{lo[7]}}, lo};
         default:                           ea = {hi, lo};
      endcase
   endfunction
   initial begin
      {clk, op_valid, test_mode, irq, op_byte, hi, lo, mem, mode, next_pc} = '0;
      {reset, miscompares, check_count, wcnt, m_sp, m_x, m_y, m_a} = '0;
      reset = 1'b1;
      m_f = 8'hD0;
      void'($urandom(34));
      repeat (16) @(negedge clk);
      reset = 1'b0;
      m_a = m_f;
      run(1'b0, xfer_test_wait_pkg::OP_FLAGS_TO_ACC, 2);
      m_sp = m_x - 16'h0001;
      run(1'b0, xfer_test_wait_pkg::OP_IDX_TO_SP, 3);
      m_y = m_sp + 16'h0001;
      run(1'b1, xfer_test_wait_pkg::OP_SP_TO_IDX, 4);
      m_x = m_sp + 16'h0001;
      run(1'b0, xfer_test_wait_pkg::OP_SP_TO_IDX, 3);
      m_sp = m_y - 16'h0001;
      run(1'b1, xfer_test_wait_pkg::OP_IDX_TO_SP, 4);
      m_f[3:0] = 4'h8;
      run(1'b0, xfer_test_wait_pkg::OP_ACC_A_CHK, 2);
      m_f[3:0] = 4'h4;
      run(1'b0, xfer_test_wait_pkg::OP_ACC_B_CHK, 2);
      m_a = m_f;
      run(1'b0, xfer_test_wait_pkg::OP_FLAGS_TO_ACC, 2);
      m_f = {m_a[7], m_a[6] & m_f[6], m_a[5:0]};
      run(1'b0, xfer_test_wait_pkg::OP_ACC_TO_FLAGS, 2);
      // memory test over every addressing mode, corners first
      for (int i = 0; i < 12; i++) begin
         r = $urandom;
         hi = r[7:0];
         lo = (i < 4) ? 8'hFF : r[15:8];
         mem = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : r[23:16];
         mode = (i < 4) ? 2'(i) : r[25:24];
         next_pc = 16'($urandom);
         m_f[3:0] = {mem[7], mem == 8'h00, 2'h0};
         run(r[26], r[26] | r[27] ? xfer_test_wait_pkg::OP_MEM_CHK_IDX
             : xfer_test_wait_pkg::OP_MEM_CHK_EXT, r[26] ? 7 : 6);
         check("addr", addr, ea(r[26]));
         check("imm16", imm16, {hi, lo});
      end
      go(1'b0, xfer_test_wait_pkg::OP_BUS_COUNT);
      check("illegal", {15'h0000, illegal}, 16'h0001);
      go(1'b0, xfer_test_wait_pkg::OP_WAIT_IRQ);
      check("wait cycles", 16'(k), 16'(14 + wcnt));
      irq = 1'b0;
      test_mode = 1'b1;
      repeat (4) @(negedge clk);
      op_valid = 1'b1;
      op_byte = xfer_test_wait_pkg::OP_BUS_COUNT;
      @(negedge clk);
      op_valid = 1'b0;
      repeat (3) @(negedge clk);
      a0 = addr;
      for (int j = 1; j < 5; j++) begin
         @(negedge clk);
         check("bus count", addr, a0 + 16'(j));
      end
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check("reset flags", {8'h00, flags}, 16'h00D0);
      conclude;
   end
endmodule
